// ==== hdl/dcbu_pkg.sv ====
package dcbu_pkg;
  // bus geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;
  // register byte offsets
  localparam logic [7:0]  OFF_INSTR   = 8'h00;
  localparam logic [7:0]  OFF_PC      = 8'h04;
  localparam logic [7:0]  OFF_FLAGS   = 8'h08;
  localparam logic [7:0]  OFF_DELAY   = 8'h0c;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_TARGET  = 8'h14;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // flag register layout
  localparam int          FLG_C       = 0;
  localparam int          FLG_Z       = 1;
  localparam int          FLG_N       = 2;
  localparam int          FLG_V       = 3;
  localparam int          FLG_W       = 5;
  // instruction halfword layout
  localparam int          OPC_HI      = 15;
  localparam int          OPC_LO      = 8;
  localparam int          REL_S       = 7;
  localparam int          REL_HI      = 6;
  localparam int          REL_LO      = 1;
  localparam int          INSN_W      = 16;
  // status register layout
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_TAKEN  = 1;
  localparam int          STAT_LEN    = 4;
  // reset values and fixed lengths
  localparam logic [31:0] PC_RST      = 32'h0000_0000;
  localparam logic [4:0]  FLAGS_RST   = 5'h00;
  localparam logic [31:0] BRANCH_LEN  = 32'h0000_0002;
  localparam logic [1:0]  LEN_BRANCH  = 2'h1;
  // fixed opcodes of this family
  localparam logic [7:0]  OP_NOT_EQUAL     = 8'he3;
  localparam logic [7:0]  OP_NO_OVERFLOW   = 8'he1;
  localparam logic [7:0]  OP_SMALLER_EQUAL = 8'he6;

  typedef enum logic {DCBU_IDLE, DCBU_DELAY} dcbu_state_e;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              aw_full;
    logic              w_full;
    logic [7:0]        waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    dcbu_state_e       st;
    logic              taken;
    logic [31:0]       pc;
    logic [31:0]       target;
    logic [4:0]        flags;
    logic [1:0]        len_code;
    logic [15:0]       instr;
  } dcbu_regs_s;
endpackage : dcbu_pkg

// ==== hdl/dcbu_branch_unit.sv ====
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - The no-carry branch loads the target into the program counter only when carry is 0.
// - The not-equal branch (opcode e3) and the nonzero branch are taken only when zero is 0.
// - The non-negative branch is taken only when the negative flag is 0.
// - The no-overflow branch (opcode e1) is taken only when the overflow flag is 0.
// - The target is the signed displacement plus the address just after the branch.
// - The displacement is sign-extended with a zero low bit, even values from -128 to 126.
// - A branch, taken or not, leaves every condition flag and the cache mode flag alone.
// - The instruction after the branch, the delay slot, always executes.
// - Not taken, the delay slot advances the program counter and length code normally.
// - Taken, the delay slot does not advance the program counter, which keeps the target.
// - A program counter read by the delay slot of a taken branch returns the target.
module dcbu_branch_unit #(
  parameter logic [7:0] OP_NO_CARRY     = 8'he5, // arbitrary
  parameter logic [7:0] OP_NON_NEGATIVE = 8'heb, // arbitrary
  parameter logic [7:0] OP_NONZERO      = 8'he7  // arbitrary
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        rvalid_unused_tie,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  dcbu_pkg::dcbu_regs_s s;
  dcbu_pkg::dcbu_regs_s next_s;

  // condition decode: bit 1 says the opcode belongs to the family, bit 0 says taken
  function automatic logic [1:0] branch_decode(input logic [7:0] op, input logic [4:0] f);
    logic [1:0] r;
    r = 2'h0;
    if (op == OP_NO_CARRY) r = {1'b1, ~f[dcbu_pkg::FLG_C]};
    else if (op == dcbu_pkg::OP_NOT_EQUAL || op == OP_NONZERO) r = {1'b1, ~f[dcbu_pkg::FLG_Z]};
    else if (op == OP_NON_NEGATIVE) r = {1'b1, ~f[dcbu_pkg::FLG_N]};
    else if (op == dcbu_pkg::OP_NO_OVERFLOW) r = {1'b1, ~f[dcbu_pkg::FLG_V]};
    else if (op == dcbu_pkg::OP_SMALLER_EQUAL)
      r = {1'b1, f[dcbu_pkg::FLG_C] | f[dcbu_pkg::FLG_Z]};
    return r;
  endfunction : branch_decode

  function automatic logic [31:0] rel_of(input logic [15:0] i);
    return {{25{i[dcbu_pkg::REL_S]}}, i[dcbu_pkg::REL_HI:dcbu_pkg::REL_LO], 1'b0};
  endfunction : rel_of

  // byte-lane merge so partial writes keep untouched bytes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < dcbu_pkg::STRB_W; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // a write executes once address and data are both held and no response is pending
  logic        wr_fire;
  logic [31:0] wr_val;
  logic [1:0]  dec;
  logic        issue;
  logic        slot_done;
  logic [31:0] flag_word;
  assign wr_fire   = s.aw_full & s.w_full & ~s.bvalid;
  assign wr_val    = merge(32'h0000_0000, s.wdata, s.wstrb);
  assign dec       = branch_decode(wr_val[dcbu_pkg::OPC_HI:dcbu_pkg::OPC_LO], s.flags);
  assign issue     = wr_fire & (s.waddr == dcbu_pkg::OFF_INSTR) & (s.st == dcbu_pkg::DCBU_IDLE)
                     & dec[1];
  assign slot_done = wr_fire & (s.waddr == dcbu_pkg::OFF_DELAY)
                     & (s.st == dcbu_pkg::DCBU_DELAY);
  assign flag_word = merge({27'h0, s.flags}, s.wdata, s.wstrb);

  // next state of bus slave and branch sequencer
  always_comb begin
    next_s = s;
    // write address and data are taken independently
    if (awvalid & s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.waddr   = awaddr;
    end
    if (wvalid & s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (s.bvalid & bready) next_s.bvalid = 1'b0;
    if (wr_fire) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = dcbu_pkg::RESP_SLVERR;
      unique case (s.waddr)
        dcbu_pkg::OFF_INSTR: begin
          if (issue) begin
            next_s.bresp  = dcbu_pkg::RESP_OKAY;
            next_s.instr  = wr_val[dcbu_pkg::INSN_W-1:0];
            next_s.target = s.pc + dcbu_pkg::BRANCH_LEN + rel_of(wr_val[dcbu_pkg::INSN_W-1:0]);
            next_s.taken  = dec[0];
            next_s.pc     = dec[0] ? s.pc + dcbu_pkg::BRANCH_LEN
                                     + rel_of(wr_val[dcbu_pkg::INSN_W-1:0])
                                   : s.pc + dcbu_pkg::BRANCH_LEN;
            next_s.len_code = dcbu_pkg::LEN_BRANCH;
            next_s.st     = dcbu_pkg::DCBU_DELAY;
          end
        end
        dcbu_pkg::OFF_PC: begin
          // the pc is frozen while a delay slot is owed
          if (s.st == dcbu_pkg::DCBU_IDLE) begin
            next_s.bresp = dcbu_pkg::RESP_OKAY;
            next_s.pc    = merge(s.pc, s.wdata, s.wstrb);
          end
        end
        dcbu_pkg::OFF_FLAGS: begin
          next_s.bresp = dcbu_pkg::RESP_OKAY;
          next_s.flags = flag_word[dcbu_pkg::FLG_W-1:0];
        end
        dcbu_pkg::OFF_DELAY: begin
          if (slot_done) begin
            next_s.bresp = dcbu_pkg::RESP_OKAY;
            next_s.st    = dcbu_pkg::DCBU_IDLE;
            if (!s.taken) begin
              next_s.pc  = s.pc + {29'h0, wr_val[1:0], 1'b0};
              next_s.len_code = wr_val[1:0];
            end
          end
        end
        default: next_s.bresp = dcbu_pkg::RESP_SLVERR;
      endcase
    end
    next_s.awready = ~next_s.aw_full & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_full & ~next_s.bvalid;
    // read channel: one outstanding read, data one edge after the address
    if (s.rvalid & rready) next_s.rvalid = 1'b0;
    if (arvalid & s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = dcbu_pkg::RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      unique case (araddr)
        dcbu_pkg::OFF_INSTR:  next_s.rdata = {16'h0000, s.instr};
        dcbu_pkg::OFF_PC:     next_s.rdata = s.pc;
        dcbu_pkg::OFF_FLAGS:  next_s.rdata = {27'h0, s.flags};
        dcbu_pkg::OFF_DELAY:  next_s.rdata = 32'h0000_0000;
        dcbu_pkg::OFF_STATUS: begin
          next_s.rdata[dcbu_pkg::STAT_BUSY]  = (s.st == dcbu_pkg::DCBU_DELAY);
          next_s.rdata[dcbu_pkg::STAT_TAKEN] = s.taken;
          next_s.rdata[dcbu_pkg::STAT_LEN +: 2] = s.len_code;
        end
        dcbu_pkg::OFF_TARGET: next_s.rdata = s.target;
        default:              next_s.rresp = dcbu_pkg::RESP_SLVERR;
      endcase
    end
    next_s.arready = ~next_s.rvalid;
  end

  // single register stage; every field has a reset constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s       <= '0;
      s.pc    <= dcbu_pkg::PC_RST;
      s.flags <= dcbu_pkg::FLAGS_RST;
      s.st    <= dcbu_pkg::DCBU_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] op_w;
  assign op_w = wr_val[dcbu_pkg::OPC_HI:dcbu_pkg::OPC_LO];

  property p_no_carry;
    issue && op_w == OP_NO_CARRY |=> s.taken == ~$past(s.flags[dcbu_pkg::FLG_C]);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("no carry branch wrong");

  property p_not_equal;
    issue && op_w == dcbu_pkg::OP_NOT_EQUAL |=> s.taken == ~$past(s.flags[dcbu_pkg::FLG_Z]);
  endproperty
  a_not_equal: assert property (p_not_equal) else $error("not equal branch wrong");

  property p_non_neg;
    issue && op_w == OP_NON_NEGATIVE |=> s.taken == ~$past(s.flags[dcbu_pkg::FLG_N]);
  endproperty
  a_non_neg: assert property (p_non_neg) else $error("non-negative branch wrong");

  property p_no_ovf;
    issue && op_w == dcbu_pkg::OP_NO_OVERFLOW |=> s.taken == ~$past(s.flags[dcbu_pkg::FLG_V]);
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("no overflow branch wrong");

  property p_smaller_eq;
    issue && op_w == dcbu_pkg::OP_SMALLER_EQUAL |=> s.taken ==
      ($past(s.flags[dcbu_pkg::FLG_C]) | $past(s.flags[dcbu_pkg::FLG_Z]));
  endproperty
  a_smaller_eq: assert property (p_smaller_eq) else $error("smaller-equal branch wrong");

  property p_target;
    issue |=> s.target == $past(s.pc) + dcbu_pkg::BRANCH_LEN + rel_of($past(wr_val[15:0]));
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_flags_kept;
    issue |=> s.flags == $past(s.flags) ##1 s.st == dcbu_pkg::DCBU_DELAY;
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("branch touched flags");

  property p_slot_seq;
    slot_done && !s.taken |=> s.pc == $past(s.pc) + {29'h0, $past(wr_val[1:0]), 1'b0}
      && s.st == dcbu_pkg::DCBU_IDLE;
  endproperty
  a_slot_seq: assert property (p_slot_seq) else $error("untaken slot pc wrong");

  property p_slot_taken;
    slot_done && s.taken |=> s.pc == $past(s.target) && s.st == dcbu_pkg::DCBU_IDLE;
  endproperty
  a_slot_taken: assert property (p_slot_taken) else $error("taken slot moved pc");

  property p_pc_target;
    s.st == dcbu_pkg::DCBU_DELAY && s.taken |-> s.pc == s.target;
  endproperty
  a_pc_target: assert property (p_pc_target) else $error("delay pc not target");

  property p_cond_hold;
    s.st == dcbu_pkg::DCBU_DELAY && !slot_done |=> $stable(s.taken) && $stable(s.pc);
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("decision changed in slot");

  property p_nonzero;
    issue && op_w == OP_NONZERO |=> s.taken == ~$past(s.flags[dcbu_pkg::FLG_Z]);
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("nonzero branch wrong");

  property p_slot_owed;
    issue |=> s.st == dcbu_pkg::DCBU_DELAY && s.len_code == dcbu_pkg::LEN_BRANCH;
  endproperty
  a_slot_owed: assert property (p_slot_owed) else $error("delay slot not owed");

  property p_reissue;
    wr_fire && s.waddr == dcbu_pkg::OFF_INSTR && s.st == dcbu_pkg::DCBU_DELAY
      |=> bresp == dcbu_pkg::RESP_SLVERR && $stable(s.target);
  endproperty
  a_reissue: assert property (p_reissue) else $error("issue in slot");

  property p_pc_frozen;
    wr_fire && s.waddr == dcbu_pkg::OFF_PC && s.st == dcbu_pkg::DCBU_DELAY
      |=> bresp == dcbu_pkg::RESP_SLVERR && $stable(s.pc);
  endproperty
  a_pc_frozen: assert property (p_pc_frozen) else $error("pc written in slot");

  property p_read_pc;
    arvalid && arready && araddr == dcbu_pkg::OFF_PC
      && s.st == dcbu_pkg::DCBU_DELAY && s.taken |=> rdata == $past(s.target);
  endproperty
  a_read_pc: assert property (p_read_pc) else $error("slot pc read not target");

endmodule : dcbu_branch_unit

`default_nettype wire

// ==== tb/test_delayed_cond_branch_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_delayed_cond_branch_unit;
  localparam logic [7:0] op_nc = 8'he5; // arbitrary
  localparam logic [7:0] op_nn = 8'heb; // arbitrary
  localparam logic [7:0] op_nz = 8'he7; // arbitrary

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          bad_count = 0;
  int          comparisons = 0;

  dcbu_branch_unit #(.OP_NO_CARRY(op_nc), .OP_NON_NEGATIVE(op_nn), .OP_NONZERO(op_nz))
  i_dcbu_branch_unit (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid_unused_tie(1'b0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));

  // free-running core clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // address and data offered together; each dropped once its own ready was seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) aw = 1'b1;
      if (wvalid && wready) w = 1'b1;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // expected decision worked out from the flag conditions of each opcode
  function automatic logic exp_take(input logic [7:0] op, input logic [4:0] f);
    case (op)
      op_nc:                      return !f[dcbu_pkg::FLG_C];
      dcbu_pkg::OP_NOT_EQUAL,
      op_nz:                      return !f[dcbu_pkg::FLG_Z];
      op_nn:                      return !f[dcbu_pkg::FLG_N];
      dcbu_pkg::OP_NO_OVERFLOW:   return !f[dcbu_pkg::FLG_V];
      default:                    return f[dcbu_pkg::FLG_C] | f[dcbu_pkg::FLG_Z];
    endcase
  endfunction : exp_take

  // one branch plus its delay slot, judged at every step
  task automatic branch(input logic [7:0] op, input logic [4:0] f, input logic [31:0] pc0,
                        input logic [7:0] rel, input logic [1:0] len);
    logic [31:0] d, tgt, seq;
    logic [1:0]  r;
    logic        tk;
    tk  = exp_take(op, f);
    tgt = pc0 + 32'h2 + {{24{rel[7]}}, rel[7:1], 1'b0};
    seq = pc0 + 32'h2 + {29'h0, len, 1'b0};
    wr(dcbu_pkg::OFF_FLAGS, {27'h0, f}, r);
    wr(dcbu_pkg::OFF_PC, pc0, r);
    wr(dcbu_pkg::OFF_INSTR, {16'h0, op, rel}, r);
    chk("issue resp", {30'h0, r}, {30'h0, dcbu_pkg::RESP_OKAY});
    rd(dcbu_pkg::OFF_TARGET, d, r);
    chk("target", d, tgt);
    rd(dcbu_pkg::OFF_STATUS, d, r);
    chk("status issue", d & 32'h33, {26'h0, 2'h1, 2'h0, tk, 1'b1});
    rd(dcbu_pkg::OFF_PC, d, r);
    chk("pc in slot", d, tk ? tgt : pc0 + 32'h2);
    wr(dcbu_pkg::OFF_DELAY, {30'h0, len}, r);
    chk("slot resp", {30'h0, r}, {30'h0, dcbu_pkg::RESP_OKAY});
    rd(dcbu_pkg::OFF_PC, d, r);
    chk("pc after slot", d, tk ? tgt : seq);
    rd(dcbu_pkg::OFF_STATUS, d, r);
    chk("busy after slot", d[0], 1'b0);
    if (!tk) chk("length code after slot", {30'h0, d[5:4]}, {30'h0, len});
    rd(dcbu_pkg::OFF_FLAGS, d, r);
    chk("flags kept", d & 32'h1f, {27'h0, f});
  endtask : branch

  // every opcode against every flag pattern, cache mode flag toggling along
  task automatic t_conditions();
    logic [7:0] ops [6];
    ops = '{op_nc, dcbu_pkg::OP_NOT_EQUAL, op_nn, dcbu_pkg::OP_NO_OVERFLOW, op_nz,
            dcbu_pkg::OP_SMALLER_EQUAL};
    foreach (ops[k])
      for (int i = 0; i < 16; i++)
        branch(ops[k], {i[0], i[3:0]}, 32'h0000_0100, 8'h10, 2'h1);
  endtask : t_conditions

  // extreme displacements and a two-halfword slot
  task automatic t_displacement();
    branch(dcbu_pkg::OP_SMALLER_EQUAL, 5'h01, 32'h0000_1000, 8'h80, 2'h2);
    branch(dcbu_pkg::OP_SMALLER_EQUAL, 5'h01, 32'h0000_1000, 8'h7e, 2'h2);
    branch(dcbu_pkg::OP_SMALLER_EQUAL, 5'h00, 32'h0000_1000, 8'h81, 2'h2);
  endtask : t_displacement

  // flags changed inside the slot must not alter a decision already made
  task automatic t_slot_hazard();
    logic [31:0] d;
    logic [1:0]  r;
    wr(dcbu_pkg::OFF_FLAGS, 32'h0, r);
    wr(dcbu_pkg::OFF_PC, 32'h0000_0200, r);
    wr(dcbu_pkg::OFF_INSTR, {16'h0, dcbu_pkg::OP_NOT_EQUAL, 8'h20}, r);
    wr(dcbu_pkg::OFF_FLAGS, 32'h2, r);
    wr(dcbu_pkg::OFF_INSTR, {16'h0, dcbu_pkg::OP_NOT_EQUAL, 8'h40}, r);
    chk("second issue refused", {30'h0, r}, {30'h0, dcbu_pkg::RESP_SLVERR});
    wr(dcbu_pkg::OFF_PC, 32'h0000_0400, r);
    chk("pc write in slot", {30'h0, r}, {30'h0, dcbu_pkg::RESP_SLVERR});
    rd(dcbu_pkg::OFF_INSTR, d, r);
    chk("instr kept", d, {16'h0, dcbu_pkg::OP_NOT_EQUAL, 8'h20});
    wr(dcbu_pkg::OFF_DELAY, 32'h1, r);
    rd(dcbu_pkg::OFF_PC, d, r);
    chk("pc hazard", d, 32'h0000_0222);
  endtask : t_slot_hazard

  // idle slot write and an unmapped read are both refused
  task automatic t_refusals();
    logic [31:0] d;
    logic [1:0]  r;
    wr(dcbu_pkg::OFF_DELAY, 32'h1, r);
    chk("idle slot resp", {30'h0, r}, {30'h0, dcbu_pkg::RESP_SLVERR});
    wr(dcbu_pkg::OFF_INSTR, {16'h0, 8'h00, 8'h10}, r);
    chk("foreign opcode resp", {30'h0, r}, {30'h0, dcbu_pkg::RESP_SLVERR});
    rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, dcbu_pkg::RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
  endtask : t_refusals

  // reset while a slot is owed drops the branch; the unit works again after
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    wr(dcbu_pkg::OFF_FLAGS, 32'h0000_001f, r);
    wr(dcbu_pkg::OFF_PC, 32'h0000_0300, r);
    wr(dcbu_pkg::OFF_INSTR, {16'h0, dcbu_pkg::OP_SMALLER_EQUAL, 8'h10}, r);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dcbu_pkg::OFF_STATUS, d, r);
    chk("status after reset", d, 32'h0);
    rd(dcbu_pkg::OFF_PC, d, r);
    chk("pc after reset", d, dcbu_pkg::PC_RST);
    rd(dcbu_pkg::OFF_FLAGS, d, r);
    chk("flags after reset", d, {27'h0, dcbu_pkg::FLAGS_RST});
    branch(op_nc, 5'h00, 32'h0000_0040, 8'hf0, 2'h3);
  endtask : t_reset

  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // watchdog: the full run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    finish_test();
  end

  // reset, then the scenarios in turn
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; awaddr = 8'h0; wvalid = 1'b0; wdata = 32'h0;
    wstrb = 4'h0; bready = 1'b0; arvalid = 1'b0; araddr = 8'h0; rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_refusals();
    t_conditions();
    t_displacement();
    t_slot_hazard();
    t_reset();
    finish_test();
  end
endmodule : test_delayed_cond_branch_unit

`default_nettype wire
